// *** hdl/dac_port_defines.svh ***
// Offsets, field positions, reset values and timing counts of the serial write port
`ifndef DAC_PORT_DEFINES_SVH
`define DAC_PORT_DEFINES_SVH

// ==========================================================
// Frame layout
`define FRAME_BITS 24
`define FRAME_LAST_EDGE 5'h17
`define FRAME_MODE_HI 17
`define FRAME_MODE_LO 16
`define FRAME_CODE_MSB 15
`define FRAME_CODE_LSB 0
`define FRAME_UNUSED_BITS 6

// ==========================================================
// Reset values
`define CODE_RESET 16'h0000
`define MODE_RESET 2'h0
`define FRAME_RESET 24'h000000
`define MIDSCALE_FLIP 16'h8000

// ==========================================================
// Timing
`define CLK_PERIOD_NS 50
`define WAKE_5V_NS 2500
`define WAKE_3V_NS 5000
`define WAKE_5V_CYC ((`WAKE_5V_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_3V_CYC ((`WAKE_3V_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W 7

`endif

// *** hdl/dac_port_pkg.sv ***
// Types shared by the serial write port files
package dac_port_pkg;

   // ==========================================================
   // Power mode, declared in field order 00, 01, 10, 11
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PD_1K,
      MODE_PD_100K,
      MODE_PD_HIGHZ
   } power_mode_e;

   typedef logic signed [15:0] code_t;
   typedef logic [15:0] tap_t;
   typedef logic [23:0] frame_t;

endpackage : dac_port_pkg

// *** hdl/pin_sync3.sv ***
// Three-stage synchroniser with agreement filter for one level
`timescale 1ns/100ps

module pin_sync3 #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic async_in, // Level from another domain
   output logic level_out // Filtered level
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // ==========================================================
   // Stage one is read only by stage two
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
         stage3_reg <= RESET_VAL;
         level_out <= RESET_VAL;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            level_out <= stage3_reg;
         end
      end
   end

endmodule : pin_sync3

// *** hdl/wake_timer.sv ***
// Down-counter timing the output wake-up after leaving power-down
`timescale 1ns/100ps
`include "dac_port_defines.svh"

module wake_timer (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic start, // Load and start the count
   input wire logic low_supply, // Selects the longer low-supply delay
   output logic done // One-cycle pulse when the delay has run out
);

   logic [`WAKE_CNT_W-1:0] cnt_reg;
   wire [`WAKE_CNT_W-1:0] load_val = low_supply ? `WAKE_CNT_W'(`WAKE_3V_CYC)
                                                 : `WAKE_CNT_W'(`WAKE_5V_CYC);
   wire cnt_last = (cnt_reg == `WAKE_CNT_W'(1));

   // ==========================================================
   // Count down; a new start restarts the delay from full
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         done <= 1'b0;
      end else if (start) begin
         cnt_reg <= load_val;
         done <= 1'b0;
      end else begin
         if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - `WAKE_CNT_W'(1);
         end
         done <= cnt_last;
      end
   end

endmodule : wake_timer

// *** hdl/dac_write_port.sv ***
// Serial write port of a 16-bit voltage-output converter with power modes
//
// Notes on behaviour
// R1 - Frame armed only by frame sync falling
// R2 - Sample data on each falling shift edge
// R3 - 24th edge loads code and mode together
// R4 - Host holds sync low for 24 edges
// R5 - Host raises sync between frames, 33 ns
// R6 - Host may idle sync low between frames
// R7 - First six frame bits are ignored
// R8 - Bits 17 and 16 are power mode
// R9 - Bits 15..0 are code, loaded at end
// R10 - Mode 00 normal, 01 1k, 10 100k, 11 open
// R11 - Mode 00 drives output from amplifier
// R12 - Power-down: 1k or 100k termination or open, analog off
// R13 - Power-down keeps the stored code
// R14 - Output valid after wake-up delay
// R15 - Early sync rise discards the frame
// R16 - Output at midscale after power-up
// R17 - Code is two's complement, zero midscale
// R18 - Host sends most significant bit first
// R19 - After execution, edges ignored until resync
// R20 - Power-up: normal mode, code zero
`timescale 1ns/100ps
`include "dac_port_defines.svh"

module dac_write_port (
   input wire logic CLK, // System clock, 20 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   input wire logic SCLK, // Shift clock from the host
   input wire logic FSYNC_N, // Frame sync, active low
   input wire logic SDIN, // Serial data in
   input wire logic SUPPLY_LOW, // High when running from the low supply
   output dac_port_pkg::code_t DAC_CODE, // Stored two's-complement code
   output dac_port_pkg::tap_t STRING_TAP, // Offset-binary tap select
   output dac_port_pkg::power_mode_e POWER_MODE, // Current power mode
   output logic AMP_DRIVE, // Amplifier drives the output pin
   output logic TERM_1K, // 1k termination to ground
   output logic TERM_100K, // 100k termination to ground
   output logic OUT_HIGHZ, // Output left open
   output logic ANALOG_ON, // Analog circuitry powered
   output logic OUT_SETTLED, // Output valid after wake-up
   output logic WRITE_DONE // Pulse when a frame has executed
);

   import dac_port_pkg::*;

   typedef enum logic [1:0] {
      ST_BOOT,
      ST_WAKE,
      ST_RUN,
      ST_DOWN
   } out_state_e;

   // ==========================================================
   // Helper functions
   function automatic tap_t to_tap(input code_t code);
      to_tap = tap_t'(code) ^ `MIDSCALE_FLIP;
   endfunction : to_tap

   function automatic logic is_down(input power_mode_e mode);
      is_down = (mode != MODE_NORMAL);
   endfunction : is_down

   // ==========================================================
   // Link-side state, clocked by the host's shift clock except link_hold_reg, which runs on CLK
   logic link_hold_reg;
   logic [4:0] bit_cnt_reg;
   frame_t serial_input_frame_reg;
   logic frame_done_reg;
   frame_t frame_word_reg;
   logic frame_toggle_reg;

   // Frame sync high clears the partial frame at once, even with SCLK stopped
   wire link_clr = FSYNC_N | link_hold_reg;
   wire frame_last = (bit_cnt_reg == `FRAME_LAST_EDGE);
   wire frame_exec = frame_last & ~frame_done_reg;
   wire [`FRAME_BITS-1:0] frame_full = {serial_input_frame_reg[`FRAME_BITS-2:0], SDIN};

   // Shift register and edge counter
   always_ff @(negedge SCLK or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt_reg <= 5'h00; // see R15
         serial_input_frame_reg <= `FRAME_RESET; // see R15
         frame_done_reg <= 1'b0; // see R1
      end else if (!frame_done_reg) begin // see R19
         serial_input_frame_reg <= frame_full; // see R2
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         if (frame_last) begin
            frame_done_reg <= 1'b1; // see R19
         end
      end
   end

   // Completed word and its event toggle survive the frame sync rising
   always_ff @(negedge SCLK or posedge link_hold_reg) begin
      if (link_hold_reg) begin
         frame_word_reg <= `FRAME_RESET;
         frame_toggle_reg <= 1'b0;
      end else if (frame_exec) begin
         frame_word_reg <= frame_full; // see R3
         frame_toggle_reg <= ~frame_toggle_reg; // see R3
      end
   end

   // ==========================================================
   // Crossings into the system clock
   logic toggle_level;
   logic fsync_level;
   logic supply_low_level;

   pin_sync3 #(.RESET_VAL(1'b0)) u_sync_toggle (
      .clk(CLK),
      .rst(SYS_RST),
      .async_in(frame_toggle_reg),
      .level_out(toggle_level)
   );

   pin_sync3 #(.RESET_VAL(1'b0)) u_sync_fsync (
      .clk(CLK),
      .rst(SYS_RST),
      .async_in(FSYNC_N),
      .level_out(fsync_level)
   );

   pin_sync3 #(.RESET_VAL(1'b0)) u_sync_supply (
      .clk(CLK),
      .rst(SYS_RST),
      .async_in(SUPPLY_LOW),
      .level_out(supply_low_level)
   );

   // Link stays cleared until frame sync is seen high, so a sync already low
   // at reset release cannot start a frame without a fresh falling edge
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         link_hold_reg <= 1'b1;
      end else if (fsync_level) begin
         link_hold_reg <= 1'b0; // see R1
      end
   end

   // ==========================================================
   // Frame execution in the system domain
   logic toggle_seen_reg;
   wire new_frame = toggle_level ^ toggle_seen_reg;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         toggle_seen_reg <= 1'b0;
      end else begin
         toggle_seen_reg <= toggle_level;
      end
   end

   // Word is stable long before the toggle is seen: the next frame needs
   // 24 more shift edges before it can overwrite it
   wire code_t frame_code = code_t'(frame_word_reg[`FRAME_CODE_MSB:`FRAME_CODE_LSB]); // see R9
   wire power_mode_e frame_mode = power_mode_e'(
      frame_word_reg[`FRAME_MODE_HI:`FRAME_MODE_LO]); // see R8, R7

   code_t code_reg;
   code_t code_next;
   power_mode_e mode_reg;
   power_mode_e mode_next;

   assign code_next = new_frame ? frame_code : code_reg; // see R3, R13
   assign mode_next = new_frame ? frame_mode : mode_reg; // see R3

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         code_reg <= code_t'(`CODE_RESET); // see R20, R16
         mode_reg <= power_mode_e'(`MODE_RESET); // see R20
      end else begin
         code_reg <= code_next;
         mode_reg <= mode_next;
      end
   end

   // ==========================================================
   // Output stage sequencing
   out_state_e state_reg;
   out_state_e state_next;
   logic wake_start;
   logic wake_done;

   always_comb begin
      state_next = state_reg;
      wake_start = 1'b0;
      case (state_reg)
         ST_BOOT: begin
            state_next = ST_WAKE;
            wake_start = 1'b1;
         end
         ST_WAKE: begin
            if (new_frame && is_down(frame_mode)) begin
               state_next = ST_DOWN; // see R12
            end else if (wake_done) begin
               state_next = ST_RUN; // see R14
            end
         end
         ST_RUN: begin
            if (new_frame && is_down(frame_mode)) begin
               state_next = ST_DOWN; // see R12
            end
         end
         ST_DOWN: begin
            if (new_frame && !is_down(frame_mode)) begin
               state_next = ST_WAKE; // see R14
               wake_start = 1'b1;
            end
         end
         default: begin
            state_next = ST_BOOT;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= ST_BOOT;
      end else begin
         state_reg <= state_next;
      end
   end

   // Delay length follows the supply at wake-up from power-down; at boot supply_low_level still holds its reset 0, so the shorter delay is used
   wake_timer u_wake (
      .clk(CLK),
      .rst(SYS_RST),
      .start(wake_start),
      .low_supply(supply_low_level),
      .done(wake_done)
   );

   // ==========================================================
   // Registered outputs
   wire pd_next = is_down(mode_next);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         DAC_CODE <= code_t'(`CODE_RESET);
         STRING_TAP <= to_tap(code_t'(`CODE_RESET)); // see R16
         POWER_MODE <= MODE_NORMAL;
         AMP_DRIVE <= 1'b1;
         TERM_1K <= 1'b0;
         TERM_100K <= 1'b0;
         OUT_HIGHZ <= 1'b0;
         ANALOG_ON <= 1'b1;
         OUT_SETTLED <= 1'b0;
         WRITE_DONE <= 1'b0;
      end else begin
         DAC_CODE <= code_next;
         STRING_TAP <= to_tap(code_next); // see R17
         POWER_MODE <= mode_next;
         AMP_DRIVE <= ~pd_next; // see R11
         TERM_1K <= (mode_next == MODE_PD_1K); // see R10
         TERM_100K <= (mode_next == MODE_PD_100K); // see R10
         OUT_HIGHZ <= (mode_next == MODE_PD_HIGHZ); // see R10
         ANALOG_ON <= ~pd_next; // see R12
         OUT_SETTLED <= (state_next == ST_RUN); // see R14
         WRITE_DONE <= new_frame;
      end
   end

endmodule : dac_write_port

// *** bench/dac_port_sva.sv ***
// Concurrent checks on the outputs of the serial write port
`timescale 1ns/100ps

module dac_port_sva (
   input wire logic CLK, // System clock
   input wire logic SYS_RST, // Synchronous reset
   input dac_port_pkg::code_t DAC_CODE, // Stored code
   input dac_port_pkg::tap_t STRING_TAP, // Tap select
   input dac_port_pkg::power_mode_e POWER_MODE, // Power mode
   input wire logic AMP_DRIVE, // Amplifier on pin
   input wire logic TERM_1K, // 1k termination
   input wire logic TERM_100K, // 100k termination
   input wire logic OUT_HIGHZ, // Open output
   input wire logic ANALOG_ON, // Analog powered
   input wire logic OUT_SETTLED, // Output valid
   input wire logic WRITE_DONE // Frame executed
);
   import dac_port_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // ==========================================
   // Wake-up steps
   sequence wake_hold;
      !OUT_SETTLED [*8];
   endsequence
   sequence wake_end;
      ##[50:104] OUT_SETTLED;
   endsequence
   // ==========================================
   // Properties
   AST_POWERUP: assert property ($fell(SYS_RST) |-> DAC_CODE == 16'h0000
      && POWER_MODE == MODE_NORMAL) else $error("power-up state wrong");
   AST_TERMS: assert property ({TERM_1K, TERM_100K, OUT_HIGHZ} ==
      {POWER_MODE == MODE_PD_1K, POWER_MODE == MODE_PD_100K, POWER_MODE == MODE_PD_HIGHZ})
      else $error("termination does not match mode");
   AST_NORMAL: assert property (POWER_MODE == MODE_NORMAL |-> AMP_DRIVE && ANALOG_ON)
      else $error("normal mode without amplifier");
   AST_PD_OFF: assert property (POWER_MODE != MODE_NORMAL |->
      !AMP_DRIVE && !ANALOG_ON && !OUT_SETTLED) else $error("power-down left analog on");
   AST_TAP: assert property (STRING_TAP == (DAC_CODE ^ 16'h8000))
      else $error("tap not offset binary of code");
   AST_HOLD: assert property ($changed(DAC_CODE) || $changed(POWER_MODE) |->
      WRITE_DONE || $past(WRITE_DONE)) else $error("state changed without a frame");
   AST_DONE_PULSE: assert property (WRITE_DONE |=> !WRITE_DONE)
      else $error("done longer than one cycle");
   AST_WAKE_HOLD: assert property ($rose(AMP_DRIVE) |-> wake_hold)
      else $error("settled too early");
   AST_WAKE_END: assert property ($rose(AMP_DRIVE) |-> wake_end)
      else $error("settled too late");
endmodule : dac_port_sva

// *** bench/host_model.sv ***
// Host serial master driving frame sync, shift clock and data
`timescale 1ns/100ps

module host_model (
   output logic SCLK, // Shift clock, still outside frames
   output logic FSYNC_N, // Frame sync
   output logic SDIN // Serial data
);
   import dac_port_pkg::*;
   initial begin
      SCLK = 1'b0;
      FSYNC_N = 1'b1;
      SDIN = 1'b0;
   end
   task automatic send(input frame_t f, input int n, input bit idle_low);
      int i;
      FSYNC_N = 1'b1;
      #45 FSYNC_N = 1'b0;
      for (i = 0; i < n; i++) begin
         #3 SDIN = (i < 24) ? f[23 - i] : ~SDIN;
         #4.5 SCLK = 1'b1;
         #7.5 SCLK = 1'b0;
      end
      #7.5 SDIN = ~SDIN;
      if (!idle_low) FSYNC_N = 1'b1;
   endtask : send
endmodule : host_model

// *** bench/tb_dac_write_port.sv ***
// Self-checking bench of the serial write port
`timescale 1ns/100ps
`include "dac_port_defines.svh"

module tb_dac_write_port;
   import dac_port_pkg::*;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic SUPPLY_LOW = 1'b0;
   wire SCLK, FSYNC_N, SDIN;
   code_t DAC_CODE;
   tap_t STRING_TAP;
   power_mode_e POWER_MODE;
   logic AMP_DRIVE, TERM_1K, TERM_100K, OUT_HIGHZ, ANALOG_ON, OUT_SETTLED, WRITE_DONE;
   logic [31:0] rng = 32'h0000AD34;
   logic [17:0] expq[$];
   logic [17:0] last, e;
   int mismatches = 0;
   int n_tests = 0;
   int settle, k;
   initial forever #25 CLK = ~CLK;
   host_model host (.SCLK(SCLK), .FSYNC_N(FSYNC_N), .SDIN(SDIN));
   dac_write_port dut (.CLK(CLK), .SYS_RST(SYS_RST), .SCLK(SCLK), .FSYNC_N(FSYNC_N),
      .SDIN(SDIN), .SUPPLY_LOW(SUPPLY_LOW), .DAC_CODE(DAC_CODE), .STRING_TAP(STRING_TAP),
      .POWER_MODE(POWER_MODE), .AMP_DRIVE(AMP_DRIVE), .TERM_1K(TERM_1K), .TERM_100K(TERM_100K),
      .OUT_HIGHZ(OUT_HIGHZ), .ANALOG_ON(ANALOG_ON), .OUT_SETTLED(OUT_SETTLED),
      .WRITE_DONE(WRITE_DONE));
   // ==========================================
   // Helpers
   function logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // Settle count starts at the done pulse; aborts just let the window pass
   task automatic frame(input frame_t f, input int n);
      int i;
      if (n >= 24) begin
         expq.push_back(f[17:0]);
         last = f[17:0];
      end
      host.send(f, n, (n >= 24) && f[16]);
      for (i = 0; i < 20 && WRITE_DONE !== 1'b1; i++) @(negedge CLK);
      settle = 0;
      while (settle < 120 && OUT_SETTLED !== 1'b1) begin
         @(negedge CLK);
         settle++;
      end
      repeat (12) @(negedge CLK);
   endtask : frame
   // ==========================================
   // Scoreboard: outputs looked at one cycle after the pulse, as they stand
   always @(negedge CLK) begin
      if (WRITE_DONE === 1'b1) begin
         @(negedge CLK);
         if (expq.size() == 0) check(1, 0);
         else begin
            e = expq.pop_front();
            check($unsigned(DAC_CODE), e[15:0]);
            check(POWER_MODE, e[17:16]);
            check(STRING_TAP, e[15:0] ^ 16'h8000);
            check({AMP_DRIVE, ANALOG_ON, TERM_1K, TERM_100K, OUT_HIGHZ}, {e[17:16] == 2'h0,
               e[17:16] == 2'h0, e[17:16] == 2'h1, e[17:16] == 2'h2, e[17:16] == 2'h3});
         end
      end
   end
   initial begin
      #400000 mismatches++;
      results();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (10) @(negedge CLK);
      SYS_RST = 1'b0;
      @(negedge CLK);
      check($unsigned(DAC_CODE), 16'h0000);
      check(STRING_TAP, 16'h8000);
      check(POWER_MODE, MODE_NORMAL);
      repeat (12) @(negedge CLK);
      for (k = 0; k < 4; k++) frame({xs() & 24'hFCFFFF} | (k << 16), 24);
      frame(xs(), 23);
      check($unsigned(DAC_CODE), last[15:0]);
      check(POWER_MODE, last[17:16]);
      frame(xs() & 24'hFCFFFF, 30);
      check(settle >= `WAKE_5V_CYC && settle <= `WAKE_5V_CYC + 3, 1);
      frame({xs() & 24'hFCFFFF} | 24'h020000, 24);
      SUPPLY_LOW = 1'b1;
      frame(xs() & 24'hFCFFFF, 24);
      check(settle >= `WAKE_3V_CYC && settle <= `WAKE_3V_CYC + 3, 1);
      check(expq.size(), 0);
      results();
   end
endmodule : tb_dac_write_port

bind dac_write_port dac_port_sva chk (.CLK(CLK), .SYS_RST(SYS_RST), .DAC_CODE(DAC_CODE),
   .STRING_TAP(STRING_TAP), .POWER_MODE(POWER_MODE), .AMP_DRIVE(AMP_DRIVE), .TERM_1K(TERM_1K),
   .TERM_100K(TERM_100K), .OUT_HIGHZ(OUT_HIGHZ), .ANALOG_ON(ANALOG_ON),
   .OUT_SETTLED(OUT_SETTLED), .WRITE_DONE(WRITE_DONE));
